// ==== port7_upper_pin_function_select.sv ====
// Decided for this implementation: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
// Function
// - bit4 input is timer A2 up/down polarity
// - bit4 input is timer A2 two-phase pulse
// - no A2 pulse output during two-phase
// - bit3 input is timer A1 gate level
// - bit2 receives serial2 clock when external
// - bit2 drives serial2 clock when internal
// - serial2 pin functions need serial enabled
// - bit4 plain port input without pull-up
// - bit4 port input pull-up from bit7
module port7_upper_pin_function_select
  import pin_select_pkg::*;
(
  input wire logic core_clk, // system clock
  input wire logic rst, // synchronous reset, high
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic port7_bit4_pin_in, // pin level
  output logic port7_bit4_pin_out, // pin drive value
  output logic port7_bit4_pin_oe, // pin drive enable
  output logic port7_bit4_pin_pullup, // pull-up enable
  input wire logic port7_bit3_pin_in, // pin level
  output logic port7_bit3_pin_out, // pin drive value
  output logic port7_bit3_pin_oe, // pin drive enable
  output logic port7_bit3_pin_pullup, // pull-up enable
  input wire logic port7_bit2_pin_in, // pin level
  output logic port7_bit2_pin_out, // pin drive value
  output logic port7_bit2_pin_oe, // pin drive enable
  output logic port7_bit2_pin_pullup, // pull-up enable
  input wire logic timer_a2_pulse, // timer A2 pulse output
  input wire logic timer_a1_pulse, // timer A1 pulse output
  input wire logic serial2_clock_out, // internal serial clock
  input wire logic request_to_send_out, // flow-control output
  input wire logic motor_w_phase, // third motor phase
  input wire logic motor_v_phase, // second motor phase
  output logic timer_a2_output_pin, // A2 up/down or two-phase in
  output logic timer_a1_input_pin, // A1 gate level in
  output logic timer_a1_output_pin, // A1 up/down polarity in
  output logic serial2_clock_pin, // external serial clock in
  output logic clear_to_send_in // flow-control input
);

  function automatic logic [11:0] byte_addr(input logic [9:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction

  // -------------------------------------------------------------
  // registers
  // -------------------------------------------------------------
  logic [7:0] three_phase_control_reg;
  logic [7:0] serial2_mode_reg;
  logic [7:0] serial2_control0_reg;
  logic [7:0] timer_trigger_select_reg;
  logic [7:0] timer_updown_flags_reg;
  logic [7:0] timer_a1_mode_reg;
  logic [7:0] timer_a2_mode_reg;
  logic [7:0] port7_direction_reg;
  logic [7:0] pullup_control_reg;
  logic [7:0] port7_data_reg;
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;

  // -------------------------------------------------------------
  // apb decode
  // -------------------------------------------------------------
  wire logic setup_phase = psel && !penable;
  wire logic write_done = psel && penable && pready && pwrite;
  wire logic hit_tp = paddr == byte_addr(three_phase_control_idx);
  wire logic hit_sm = paddr == byte_addr(serial2_mode_idx);
  wire logic hit_sc = paddr == byte_addr(serial2_control0_idx);
  wire logic hit_ts = paddr == byte_addr(timer_trigger_select_idx);
  wire logic hit_ud = paddr == byte_addr(timer_updown_flags_idx);
  wire logic hit_a1 = paddr == byte_addr(timer_a1_mode_idx);
  wire logic hit_a2 = paddr == byte_addr(timer_a2_mode_idx);
  wire logic hit_dir = paddr == byte_addr(port7_direction_idx);
  wire logic hit_pu = paddr == byte_addr(pullup_control_idx);
  wire logic hit_dat = paddr == byte_addr(port7_data_idx);
  wire logic hit_st = paddr == byte_addr(pin_function_status_idx);
  wire logic hit_any = hit_tp || hit_sm || hit_sc || hit_ts || hit_ud ||
    hit_a1 || hit_a2 || hit_dir || hit_pu || hit_dat || hit_st;

  // -------------------------------------------------------------
  // selection terms
  // -------------------------------------------------------------
  wire logic three_phase = three_phase_control_reg[three_phase_mode_bit];
  wire logic [2:0] serial_mode = serial2_mode_reg[serial_mode_lsb +: 3];
  wire logic serial_on = serial_mode != serial_mode_off;
  wire logic clock_sync = serial_mode == serial_mode_clock_sync;
  wire logic ext_clock = serial2_mode_reg[serial_ext_clock_bit];
  wire logic flow_dis = serial2_control0_reg[flow_disable_bit];
  wire logic flow_sel = serial2_control0_reg[flow_select_bit];
  wire logic a2_two_phase = timer_updown_flags_reg[a2_two_phase_bit];
  wire logic a2_m4 = timer_a2_mode_reg[timer_mode_bit4];
  wire logic a2_m2 = timer_a2_mode_reg[timer_mode_bit2];
  wire logic a1_m4 = timer_a1_mode_reg[timer_mode_bit4];
  wire logic a1_m2 = timer_a1_mode_reg[timer_mode_bit2];
  wire logic a1_trig_none = !timer_trigger_select_reg[a1_trigger_bit1] &&
    !timer_trigger_select_reg[a1_trigger_bit0];
  wire logic dir4 = port7_direction_reg[pin4_bit];
  wire logic dir3 = port7_direction_reg[pin3_bit];
  wire logic dir2 = port7_direction_reg[pin2_bit];
  wire logic pu_hi = pullup_control_reg[pullup_p74_p77_bit];
  wire logic pu_lo = pullup_control_reg[pullup_p70_p73_bit];

  // pin 4: motor phase, then A2 pulse out, then port
  // the pulse output is withheld while two-phase counting is on
  wire logic p4_motor = three_phase;
  wire logic p4_pulse = !three_phase && a2_m2 && !a2_two_phase;
  wire logic p4_port_out = !three_phase && !a2_m2 && dir4;
  wire logic p4_input = !p4_motor && !p4_pulse && !p4_port_out;
  wire logic p4_timer_in = p4_input && !dir4 && a2_m4 && !a2_m2;
  wire logic p4_updown = p4_timer_in && !a2_two_phase;
  wire logic p4_twophase = p4_timer_in && a2_two_phase;
  wire logic p4_pull = p4_input && pu_hi;

  // pin 3: motor phase, then request-to-send, then port
  wire logic p3_motor = three_phase;
  wire logic p3_rts = !three_phase && serial_on && !flow_dis && flow_sel;
  wire logic p3_port_out = !p3_motor && !p3_rts && dir3;
  wire logic p3_input = !p3_motor && !p3_rts && !dir3;
  wire logic p3_cts = p3_input && serial_on && !flow_dis && !flow_sel;
  wire logic p3_gate = p3_input && a1_trig_none && a1_m4;
  wire logic p3_pull = p3_input && pu_lo;

  // pin 2: motor phase, serial clock out, A1 pulse out, then port
  // the serial clock only exists in clock-synchronous mode
  wire logic clk_pin_ok = !three_phase && serial_on && clock_sync && !pu_lo;
  wire logic p2_motor = three_phase;
  wire logic p2_clk_out = clk_pin_ok && !ext_clock;
  wire logic p2_pulse = !three_phase && !p2_clk_out && a1_m2;
  wire logic p2_port_out = !three_phase && !p2_clk_out && !a1_m2 && dir2;
  wire logic p2_input = !p2_motor && !p2_clk_out && !p2_pulse && !dir2;
  wire logic p2_clk_in = p2_input && clk_pin_ok && ext_clock;
  wire logic p2_updown = p2_input && a1_m4;
  wire logic p2_pull = p2_input && pu_lo;

  wire logic p4_oe = !p4_input;
  wire logic p3_oe = !p3_input;
  wire logic p2_oe = !p2_input;
  wire logic p4_drive = p4_motor ? motor_w_phase :
    p4_pulse ? timer_a2_pulse : port7_data_reg[pin4_bit];
  wire logic p3_drive = p3_motor ? motor_v_phase :
    p3_rts ? request_to_send_out : port7_data_reg[pin3_bit];
  wire logic p2_drive = p2_motor ? motor_v_phase :
    p2_clk_out ? serial2_clock_out :
    p2_pulse ? timer_a1_pulse : port7_data_reg[pin2_bit];

  // -------------------------------------------------------------
  // status readback
  // -------------------------------------------------------------
  function automatic pin_fn_t pin_fn(input logic motor, input logic po,
                                     input logic periph_out,
                                     input logic periph_in);
    if (motor) begin
      pin_fn = fn_motor_out;
    end else if (periph_out) begin
      pin_fn = fn_periph_out;
    end else if (po) begin
      pin_fn = fn_port_out;
    end else if (periph_in) begin
      pin_fn = fn_periph_in;
    end else begin
      pin_fn = fn_port_in;
    end
  endfunction

  wire pin_fn_t fn4 = pin_fn(p4_motor, p4_port_out, p4_pulse, p4_timer_in);
  wire pin_fn_t fn3 = pin_fn(p3_motor, p3_port_out, p3_rts,
                             p3_cts || p3_gate);
  wire pin_fn_t fn2 = pin_fn(p2_motor, p2_port_out,
                             p2_clk_out || p2_pulse, p2_clk_in || p2_updown);
  wire logic [7:0] data_rd = {port7_data_reg[7:5], sync2_reg,
                              port7_data_reg[1:0]};
  wire logic [31:0] rd_mux =
    hit_tp ? {24'h0, three_phase_control_reg} :
    hit_sm ? {24'h0, serial2_mode_reg} :
    hit_sc ? {24'h0, serial2_control0_reg} :
    hit_ts ? {24'h0, timer_trigger_select_reg} :
    hit_ud ? {24'h0, timer_updown_flags_reg} :
    hit_a1 ? {24'h0, timer_a1_mode_reg} :
    hit_a2 ? {24'h0, timer_a2_mode_reg} :
    hit_dir ? {24'h0, port7_direction_reg} :
    hit_pu ? {24'h0, pullup_control_reg} :
    hit_dat ? {24'h0, data_rd} :
    hit_st ? {23'h0, fn4, fn3, fn2} : 32'h0;

  // -------------------------------------------------------------
  // bus response: one access cycle, answered from the setup cycle
  // -------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= setup_phase;
      pslverr <= setup_phase && !hit_any;
      prdata <= (setup_phase && !pwrite) ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      three_phase_control_reg <= reg_reset_value;
      serial2_mode_reg <= reg_reset_value;
      serial2_control0_reg <= reg_reset_value;
      timer_trigger_select_reg <= reg_reset_value;
      timer_updown_flags_reg <= reg_reset_value;
      timer_a1_mode_reg <= reg_reset_value;
      timer_a2_mode_reg <= reg_reset_value;
      port7_direction_reg <= reg_reset_value;
      pullup_control_reg <= reg_reset_value;
      port7_data_reg <= reg_reset_value;
    end else if (write_done) begin
      if (hit_tp) three_phase_control_reg <= pwdata[7:0];
      if (hit_sm) serial2_mode_reg <= pwdata[7:0];
      if (hit_sc) serial2_control0_reg <= pwdata[7:0];
      if (hit_ts) timer_trigger_select_reg <= pwdata[7:0];
      if (hit_ud) timer_updown_flags_reg <= pwdata[7:0];
      if (hit_a1) timer_a1_mode_reg <= pwdata[7:0];
      if (hit_a2) timer_a2_mode_reg <= pwdata[7:0];
      if (hit_dir) port7_direction_reg <= pwdata[7:0];
      if (hit_pu) pullup_control_reg <= pwdata[7:0];
      if (hit_dat) port7_data_reg <= pwdata[7:0];
    end
  end

  // -------------------------------------------------------------
  // pins: inputs synchronised, outputs registered
  // -------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
    end else begin
      sync1_reg <= {port7_bit4_pin_in, port7_bit3_pin_in,
                    port7_bit2_pin_in};
      sync2_reg <= sync1_reg;
    end
  end

  // a function input reads low while its pin is not selected,
  // so a stray pin level never reaches an idle timer or channel
  always_ff @(posedge core_clk) begin
    if (rst) begin
      port7_bit4_pin_out <= 1'b0;
      port7_bit4_pin_oe <= 1'b0;
      port7_bit4_pin_pullup <= 1'b0;
      port7_bit3_pin_out <= 1'b0;
      port7_bit3_pin_oe <= 1'b0;
      port7_bit3_pin_pullup <= 1'b0;
      port7_bit2_pin_out <= 1'b0;
      port7_bit2_pin_oe <= 1'b0;
      port7_bit2_pin_pullup <= 1'b0;
      timer_a2_output_pin <= 1'b0;
      timer_a1_input_pin <= 1'b0;
      timer_a1_output_pin <= 1'b0;
      serial2_clock_pin <= 1'b0;
      clear_to_send_in <= 1'b0;
    end else begin
      port7_bit4_pin_out <= p4_drive;
      port7_bit4_pin_oe <= p4_oe;
      port7_bit4_pin_pullup <= p4_pull;
      port7_bit3_pin_out <= p3_drive;
      port7_bit3_pin_oe <= p3_oe;
      port7_bit3_pin_pullup <= p3_pull;
      port7_bit2_pin_out <= p2_drive;
      port7_bit2_pin_oe <= p2_oe;
      port7_bit2_pin_pullup <= p2_pull;
      timer_a2_output_pin <= (p4_updown || p4_twophase) && sync2_reg[2];
      timer_a1_input_pin <= p3_gate && sync2_reg[1];
      timer_a1_output_pin <= p2_updown && sync2_reg[0];
      serial2_clock_pin <= p2_clk_in && sync2_reg[0];
      clear_to_send_in <= p3_cts && sync2_reg[1];
    end
  end

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_a2_updown;
    !dir4 && a2_m4 && !a2_m2 && !a2_two_phase && !three_phase
      |=> !port7_bit4_pin_oe;
  endproperty
  a_a2_updown: assert property (p_a2_updown)
    else $error("bit4 driven while timer A2 up/down input");
  property p_a2_twophase;
    p4_twophase && $stable(sync2_reg[2])
      |=> timer_a2_output_pin == $past(sync2_reg[2]);
  endproperty
  a_a2_twophase: assert property (p_a2_twophase)
    else $error("two-phase input not passed from bit4");
  property p_no_pulse_twophase;
    a2_two_phase && !three_phase |=> port7_bit4_pin_out ==
      (port7_bit4_pin_oe ? $past(port7_data_reg[pin4_bit]) : 1'b0) ||
      !port7_bit4_pin_oe;
  endproperty
  a_no_pulse_twophase: assert property (p_no_pulse_twophase)
    else $error("timer A2 pulse driven during two-phase");
  property p_a1_gate;
    !dir3 && a1_trig_none && a1_m4 && !three_phase && !p3_rts &&
      sync2_reg[1] |=> timer_a1_input_pin;
  endproperty
  a_a1_gate: assert property (p_a1_gate)
    else $error("gate level not passed from bit3");
  property p_clk_in;
    serial2_clock_pin |-> $past(ext_clock) && !port7_bit2_pin_oe;
  endproperty
  a_clk_in: assert property (p_clk_in)
    else $error("serial clock input while not external");
  property p_clk_out;
    clock_sync && !ext_clock && !pu_lo && !three_phase
      |=> port7_bit2_pin_oe && port7_bit2_pin_out == $past(serial2_clock_out);
  endproperty
  a_clk_out: assert property (p_clk_out)
    else $error("serial clock not driven on bit2");
  property p_serial_off;
    !serial_on ##1 !serial_on |-> !clear_to_send_in && !serial2_clock_pin;
  endproperty
  a_serial_off: assert property (p_serial_off)
    else $error("serial pin function while serial disabled");
  property p_no_pull;
    !pu_hi |=> !port7_bit4_pin_pullup;
  endproperty
  a_no_pull: assert property (p_no_pull)
    else $error("bit4 pull-up without control bit");
  property p_pull;
    pu_hi && !dir4 && !three_phase && !a2_m2 |=> port7_bit4_pin_pullup;
  endproperty
  a_pull: assert property (p_pull)
    else $error("bit4 pull-up missing");
  property p_motor;
    three_phase |=> port7_bit4_pin_oe && port7_bit3_pin_oe &&
      port7_bit2_pin_out == $past(motor_v_phase);
  endproperty
  a_motor: assert property (p_motor)
    else $error("motor phases not driven");
  property p_rts;
    serial_on && !flow_dis && flow_sel && !three_phase
      |=> port7_bit3_pin_oe && !clear_to_send_in;
  endproperty
  a_rts: assert property (p_rts)
    else $error("request-to-send not driven on bit3");

endmodule
`default_nettype wire

// ==== pin_select_pkg.sv ====
package pin_select_pkg;
  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [9:0] three_phase_control_idx = 10'h348;
  localparam logic [9:0] serial2_mode_idx = 10'h378;
  localparam logic [9:0] serial2_control0_idx = 10'h37c;
  localparam logic [9:0] timer_trigger_select_idx = 10'h383;
  localparam logic [9:0] timer_updown_flags_idx = 10'h384;
  localparam logic [9:0] timer_a1_mode_idx = 10'h397;
  localparam logic [9:0] timer_a2_mode_idx = 10'h398;
  localparam logic [9:0] port7_direction_idx = 10'h3ef;
  localparam logic [9:0] pullup_control_idx = 10'h3fd;
  localparam logic [9:0] port7_data_idx = 10'h3ed;
  localparam logic [9:0] pin_function_status_idx = 10'h3ec;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] reg_reset_value = 8'h00;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int three_phase_mode_bit = 2;
  localparam int serial_mode_lsb = 0;
  localparam int serial_ext_clock_bit = 3;
  localparam int flow_disable_bit = 4;
  localparam int flow_select_bit = 2;
  localparam int a1_trigger_bit1 = 1;
  localparam int a1_trigger_bit0 = 0;
  localparam int a2_two_phase_bit = 5;
  localparam int timer_mode_bit4 = 4;
  localparam int timer_mode_bit2 = 2;
  localparam int pin4_bit = 4;
  localparam int pin3_bit = 3;
  localparam int pin2_bit = 2;
  localparam int pullup_p74_p77_bit = 7;
  localparam int pullup_p70_p73_bit = 6;
  // serial mode field: 000 disabled, 001 clock synchronous
  localparam logic [2:0] serial_mode_off = 3'h0;
  localparam logic [2:0] serial_mode_clock_sync = 3'h1;
  // ---------------------------------------------------------------
  // pin function, reported per pin in the status register
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    fn_port_in,
    fn_port_out,
    fn_periph_in,
    fn_periph_out,
    fn_motor_out
  } pin_fn_t;
endpackage

// ==== port7_pin_partner.sv ====
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------
// external circuitry on the three port-7 pins (index 2 = bit4)
// ---------------------------------------------------------------
module port7_pin_partner (
  input wire logic core_clk, // system clock
  input wire logic [2:0] drv_out, // device drive value
  input wire logic [2:0] drv_oe, // device drive enable
  input wire logic [2:0] drv_pullup, // device pull-up enable
  input wire logic [2:0] ext_en, // outside driver active
  input wire logic [2:0] ext_val, // outside driver value
  output logic [2:0] level // resolved pin level
);
  logic [2:0] last_q = 3'h0;
  // an undriven, unpulled pin toggles so a stale value cannot pass
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (drv_oe[i]) level[i] = drv_out[i];
      else if (ext_en[i]) level[i] = ext_val[i];
      else if (drv_pullup[i]) level[i] = 1'b1;
      else level[i] = ~last_q[i];
    end
  end
  always @(posedge core_clk) last_q <= level;
endmodule
`default_nettype wire

// ==== tb_port7_upper_pin_function_select.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_port7_upper_pin_function_select;
  import pin_select_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic [2:0] pin_in, pin_out, pin_oe, pin_pu;
  logic [2:0] ext_en = 3'h7, ext_val = 3'h0;
  logic a2p = 1'b0, a1p = 1'b0, sck = 1'b0, rts = 1'b0, mw = 1'b0, mv = 1'b0;
  logic a2_in, a1_gate, a1_out, clk_in, cts;
  int num_errors = 0;
  int checked = 0;
  logic [9:0] regs [9] = '{three_phase_control_idx, serial2_mode_idx,
    serial2_control0_idx, timer_trigger_select_idx, timer_updown_flags_idx,
    timer_a1_mode_idx, timer_a2_mode_idx, port7_direction_idx,
    pullup_control_idx};
  logic [6:0] corner [5] = '{7'h0e, 7'h1e, 7'h23, 7'h02, 7'h2a};
  always #5 core_clk = ~core_clk;
  port7_upper_pin_function_select port7_upper_pin_function_select_inst (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .port7_bit4_pin_in(pin_in[2]), .port7_bit4_pin_out(pin_out[2]),
    .port7_bit4_pin_oe(pin_oe[2]), .port7_bit4_pin_pullup(pin_pu[2]),
    .port7_bit3_pin_in(pin_in[1]), .port7_bit3_pin_out(pin_out[1]),
    .port7_bit3_pin_oe(pin_oe[1]), .port7_bit3_pin_pullup(pin_pu[1]),
    .port7_bit2_pin_in(pin_in[0]), .port7_bit2_pin_out(pin_out[0]),
    .port7_bit2_pin_oe(pin_oe[0]), .port7_bit2_pin_pullup(pin_pu[0]),
    .timer_a2_pulse(a2p), .timer_a1_pulse(a1p), .serial2_clock_out(sck),
    .request_to_send_out(rts), .motor_w_phase(mw), .motor_v_phase(mv),
    .timer_a2_output_pin(a2_in), .timer_a1_input_pin(a1_gate),
    .timer_a1_output_pin(a1_out), .serial2_clock_pin(clk_in),
    .clear_to_send_in(cts));
  port7_pin_partner port7_pin_partner_inst (.core_clk(core_clk),
    .drv_out(pin_out), .drv_oe(pin_oe), .drv_pullup(pin_pu),
    .ext_en(ext_en), .ext_val(ext_val), .level(pin_in));
  // ---------------------------------------------------------------
  // checking and closing
  // ---------------------------------------------------------------
  task chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task conclude;
    $display("checked=%0d num_errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    conclude;
  end
  // ---------------------------------------------------------------
  // bus master: request held until the edge that samples pready high
  // ---------------------------------------------------------------
  task apb(input logic is_wr, input logic [9:0] idx, input logic [31:0] wd,
           output logic [31:0] rd, output logic err);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= is_wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) num_errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [9:0] idx, input logic [7:0] v);
    logic [31:0] d;
    logic e;
    apb(1'b1, idx, {24'($urandom), v}, d, e);
  endtask
  task rdc(input logic [9:0] idx, input logic [31:0] exp, input logic ee);
    logic [31:0] d;
    logic e;
    apb(1'b0, idx, 32'h0, d, e);
    chk_word(d, exp);
    chk_bit(e, ee);
  endtask
  task settle;
    repeat (5) @(posedge core_clk);
    #1;
  endtask
  // pin-level follow check on one of the captured input functions
  task follow(input int sel, input logic en);
    logic g;
    for (int v = 0; v < 2; v++) begin
      @(posedge core_clk);
      ext_val <= {3{v[0]}};
      settle;
      case (sel)
        0: g = a1_gate;
        1: g = clk_in;
        default: g = cts;
      endcase
      chk_bit(g, en & v[0]);
    end
  endtask
  // expected bit4 {oe, out, pullup, captured level}
  function automatic logic [3:0] exp4(input logic [6:0] r, input logic p,
                                      input logic w, input logic lvl);
    logic oe, o;
    if (r[0]) {oe, o} = {1'b1, w};
    else if (r[2] && !r[3]) {oe, o} = {1'b1, p};
    else if (r[4] && !r[2]) {oe, o} = {1'b1, r[6]};
    else {oe, o} = 2'b00;
    return {oe, o, !oe && r[5], !r[0] && !r[4] && r[1] && !r[2] && lvl};
  endfunction
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [7:0] v;
    logic [6:0] r;
    logic [3:0] e4;
    void'($urandom(42920));
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    foreach (regs[i]) rdc(regs[i], 32'h0, 1'b0);
    rdc(10'h000, 32'h0, 1'b1);
    wr(10'h000, 8'h5a);
    rdc(10'h000, 32'h0, 1'b1);
    foreach (regs[i]) begin
      v = 8'($urandom);
      wr(regs[i], v);
      rdc(regs[i], {24'h0, v}, 1'b0);
    end
    for (int k = 0; k < 40; k++) begin
      r = (k < 5) ? corner[k] : 7'($urandom);
      @(posedge core_clk);
      {a2p, a1p, mw, mv, sck, rts} <= 6'($urandom);
      ext_val <= 3'($urandom);
      wr(three_phase_control_idx, 8'(r[0]) << three_phase_mode_bit);
      wr(timer_a2_mode_idx,
         (8'(r[1]) << timer_mode_bit4) | (8'(r[2]) << timer_mode_bit2));
      wr(timer_updown_flags_idx, 8'(r[3]) << a2_two_phase_bit);
      wr(port7_direction_idx, 8'(r[4]) << pin4_bit);
      wr(pullup_control_idx, 8'(r[5]) << pullup_p74_p77_bit);
      wr(port7_data_idx, 8'(r[6]) << pin4_bit);
      settle;
      e4 = exp4(r, a2p, mw, ext_val[2]);
      chk_bit(pin_oe[2], e4[3]);
      if (e4[3]) chk_bit(pin_out[2], e4[2]);
      chk_bit(pin_pu[2], e4[1]);
      chk_bit(a2_in, e4[0]);
      if (r[0]) chk_word({30'h0, pin_oe[1:0]}, 32'h3);
      if (r[0]) chk_word({30'h0, pin_out[1:0]}, {30'h0, mv, mv});
    end
    foreach (regs[i]) wr(regs[i], 8'h00);
    wr(timer_a1_mode_idx, 8'h10);
    follow(0, 1'b1);
    chk_bit(a1_out, 1'b1);
    wr(timer_a1_mode_idx, 8'h00);
    wr(serial2_mode_idx, 8'h09);
    follow(1, 1'b1);
    wr(serial2_mode_idx, 8'h08);
    follow(1, 1'b0);
    wr(pullup_control_idx, 8'h40);
    wr(serial2_mode_idx, 8'h09);
    follow(1, 1'b0);
    chk_word({29'h0, pin_pu}, 32'h3);
    wr(pullup_control_idx, 8'h00);
    wr(serial2_mode_idx, 8'h01);
    wr(port7_direction_idx, 8'h04);
    wr(serial2_control0_idx, 8'h04);
    for (int k = 0; k < 2; k++) begin
      @(posedge core_clk);
      {sck, rts} <= {2{k[0]}};
      settle;
      chk_word({30'h0, pin_oe[1:0]}, 32'h3);
      chk_word({30'h0, pin_out[1:0]}, {30'h0, rts, sck});
    end
    wr(serial2_mode_idx, 8'h00);
    settle;
    chk_bit(pin_oe[1], 1'b0);
    wr(serial2_mode_idx, 8'h01);
    wr(serial2_control0_idx, 8'h00);
    follow(2, 1'b1);
    wr(serial2_control0_idx, 8'h10);
    follow(2, 1'b0);
    rdc(pin_function_status_idx, 32'h3, 1'b0);
    wr(three_phase_control_idx, 8'h04);
    rdc(pin_function_status_idx, 32'h124, 1'b0);
    conclude;
  end
endmodule
`default_nettype wire
